// [lin_hdr_pkg.sv]
package lin_hdr_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] BRKLEN_OFFSET = 8'h08;
    localparam logic [7:0] MEAS_OFFSET   = 8'h0C;
    localparam logic [7:0] RATE_OFFSET   = 8'h10;
    localparam logic [7:0] TPER_OFFSET   = 8'h14;

    // Control register fields
    localparam int ARM_BIT       = 0;
    localparam int BRK_IE_BIT    = 1;
    localparam int SYNC_IE_BIT   = 2;
    localparam int SYNC_UART_BIT = 3;

    // Status register fields
    localparam int BRK_FLAG_BIT  = 0;
    localparam int SYNC_FLAG_BIT = 1;
    localparam int BUSY_BIT      = 2;
    localparam int ID_PEND_BIT   = 3;
    localparam int RESP_BIT      = 4;

    // Reset values and counts
    localparam logic [15:0] BRKLEN_RESET  = 16'h0100;
    localparam logic [3:0]  SYNC_EDGES    = 4'h8;
    localparam logic [3:0]  SYNC_BITS     = 4'h8;
    localparam int          MEAS_W        = 20;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BREAK,
        ST_BRK_END,
        ST_SYNC,
        ST_CALC,
        ST_ID,
        ST_RESP
    } hdr_state_type;

endpackage : lin_hdr_pkg

// [lin_slave_header_receiver.sv]
// Operation
// - Writing one to the arm bit enables break detection on receive line.
// - Low longer than programmed timer interval is a break; set break flag.
// - Break with break interrupt enable set raises the header interrupt.
// - After a break, go on to measure the sync field.
// - Sync field carries byte 0x55, sent by master, received here.
// - Time the span from start bit through data bit six.
// - A control bit passes the sync byte to the UART or withholds it.
// - End of sync measurement sets the sync-done flag.
// - Sync done with sync interrupt enable set raises the header interrupt.
// - Compute bit rate from the count and load it into the UART.
// - Also rewrite the timer prescaler and period with updated values.
// - After rate setup, receive the identifier through the UART.
// - After the identifier, continue with the response field exchange.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module lin_slave_header_receiver
    import lin_hdr_pkg::*;
#(
    parameter int MW = lin_hdr_pkg::MEAS_W
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // LIN receive line and UART side
    input  wire logic                 lin_rxd,
    output logic                      uart_rxd,
    output logic                      uart_rate_load,
    output logic [MW-1:0]             uart_rate,
    input  wire logic                 uart_byte_valid,
    // Timer update and interrupt
    output logic [7:0]                measure_timer_prescaler,
    output logic [15:0]               measure_timer_period,
    output logic                      header_interrupt
);
    import lin_hdr_pkg::*;

    hdr_state_type     state_r, state_nxt;
    logic [3:0]        ctrl_r;
    logic              brk_flag_r, sync_flag_r;
    logic [15:0]       brklen_r;
    logic [MW-1:0]     cnt_r, meas_r;
    logic [3:0]        edge_r;
    logic              rxd_d_r;
    logic [31:0]       prdata_nxt;

    // Bus decode
    wire wr_en    = psel & penable & pwrite;
    wire rd_en    = psel & penable & ~pwrite;
    wire hit_ctrl = paddr == CTRL_OFFSET;
    wire hit_stat = paddr == STATUS_OFFSET;
    wire hit_blen = paddr == BRKLEN_OFFSET;
    wire hit_meas = paddr == MEAS_OFFSET;
    wire hit_rate = paddr == RATE_OFFSET;
    wire hit_tper = paddr == TPER_OFFSET;
    wire mapped   = hit_ctrl | hit_stat | hit_blen | hit_meas | hit_rate | hit_tper;
    wire arm_wr   = wr_en & hit_ctrl & pwdata[ARM_BIT];
    // Writes act at the answer edge only, so no half-taken write is seen
    wire wr_take  = wr_en & pready;
    wire arm_take = arm_wr & pready;

    // State decode, shared by the counters and the read mux
    wire in_idle    = state_r == ST_IDLE;
    wire in_break   = state_r == ST_BREAK;
    wire in_brk_end = state_r == ST_BRK_END;
    wire in_sync_st = state_r == ST_SYNC;
    wire in_calc    = state_r == ST_CALC;
    wire in_id      = state_r == ST_ID;
    wire in_resp    = state_r == ST_RESP;

    // Line events; the history flop idles high so reset gives no false edge
    wire fall_edge = rxd_d_r & ~lin_rxd;
    wire rise_edge = ~rxd_d_r & lin_rxd;
    wire any_edge  = fall_edge | rise_edge;

    // Break threshold in clock cycles, widened to the counter
    wire [MW-1:0] brk_limit = {{(MW-16){1'b0}}, brklen_r};
    // A high sample restarts the low count, so short dips never add up
    wire brk_hit  = in_break & ~lin_rxd & (cnt_r > brk_limit);
    // First fall after the delimiter is the start bit of the sync byte
    wire sync_go  = in_brk_end & fall_edge;
    // Start bit through bit 6 of 0x55 ends on the 8th edge after the start fall
    wire sync_end = in_sync_st & any_edge & (edge_r == SYNC_EDGES - 4'h1);

    // Flag clears by writing one; they act at the answer edge only
    wire brk_clr  = wr_take & hit_stat & pwdata[BRK_FLAG_BIT];
    wire sync_clr = wr_take & hit_stat & pwdata[SYNC_FLAG_BIT];

    // Eight bit cells measured, start bit through bit 6
    // Truncation loses under one clock per bit; slow links lose least
    wire [MW-1:0] bit_time = meas_r / MW'(SYNC_BITS);

    // Counter: low time in break search, clock cycles in the sync byte
    // Arming clears it, so a count left from the last frame is no break
    wire [MW-1:0] cnt_inc = cnt_r + MW'(1);
    wire [MW-1:0] cnt_nxt = arm_take   ? {MW{1'b0}} :
                            in_break   ? (lin_rxd ? {MW{1'b0}} : cnt_inc) :
                            sync_go    ? MW'(1) :
                            in_sync_st ? cnt_inc : cnt_r;

    // Edge counter restarts at the start fall and counts every edge while in the sync state
    wire [3:0] edge_inc = edge_r + 4'h1;
    wire [3:0] edge_nxt = sync_go                 ? 4'h0 :
                          (in_sync_st & any_edge) ? edge_inc : edge_r;

    // Captured sync span, kept for software and the rate divide
    wire [MW-1:0] meas_nxt = sync_end ? cnt_r : meas_r;

    // Tail of the sync byte: bit 7 is still low when the measurement ends
    // Without it a withheld byte would hand bit 7 to the UART as a start bit
    logic tail_r;
    wire  tail_nxt = sync_end | (tail_r & ~rise_edge);

    // Withholding keeps the UART line idle high from break end to the stop bit
    wire withhold     = ~ctrl_r[SYNC_UART_BIT] & (in_brk_end | in_sync_st | tail_r);
    wire uart_rxd_nxt = withhold | lin_rxd;

    // Timer rewrite: prescaler takes bits 15:8, period the low 16 bits
    // A bit time of 64K clocks or more does not fit the period field
    wire [7:0]  prescaler_nxt = bit_time[15:8];
    wire [15:0] period_nxt    = bit_time[15:0];

    // Either enabled flag drives the shared interrupt line
    wire irq_brk  = brk_flag_r & ctrl_r[BRK_IE_BIT];
    wire irq_sync = sync_flag_r & ctrl_r[SYNC_IE_BIT];
    wire irq_nxt  = irq_brk | irq_sync;

    // Status word built from the field positions
    logic [31:0] status_word;
    always_comb begin
        status_word                = 32'h0000_0000;
        status_word[BRK_FLAG_BIT]  = brk_flag_r;
        status_word[SYNC_FLAG_BIT] = sync_flag_r;
        status_word[BUSY_BIT]      = ~in_idle;
        status_word[ID_PEND_BIT]   = in_id;
        status_word[RESP_BIT]      = in_resp;
    end

    // Next state; a new arm restarts the search from any state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:    state_nxt = ST_IDLE;
            ST_BREAK:   if (brk_hit) state_nxt = ST_BRK_END;
            ST_BRK_END: if (sync_go) state_nxt = ST_SYNC;
            ST_SYNC:    if (sync_end) state_nxt = ST_CALC;
            ST_CALC:    state_nxt = ST_ID;
            ST_ID:      if (uart_byte_valid) state_nxt = ST_RESP;
            ST_RESP:    state_nxt = ST_RESP;
        endcase
        if (arm_take) state_nxt = ST_BREAK;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (hit_ctrl) prdata_nxt[3:0] = ctrl_r;
        if (hit_stat) prdata_nxt = status_word;
        if (hit_blen) prdata_nxt[15:0] = brklen_r;
        if (hit_meas) prdata_nxt[MW-1:0] = meas_r;
        if (hit_rate) prdata_nxt[MW-1:0] = uart_rate;
        if (hit_tper) prdata_nxt[23:0] = {measure_timer_prescaler, measure_timer_period};
    end

    // APB answer: one wait state so read data comes from a flop
    // Costs a cycle per access but keeps the read path short
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= rd_en ? prdata_nxt : 32'h0000_0000;
            pslverr <= psel & penable & ~pready & ~mapped;
        end
    end

    // Software registers; write lands at the cycle pready is high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r   <= 4'h0;
            brklen_r <= BRKLEN_RESET;
        end else if (wr_take) begin
            if (hit_ctrl) ctrl_r <= {pwdata[3:1], 1'b0}; // arm reads back as zero
            if (hit_blen) brklen_r <= pwdata[15:0];
        end
    end

    // Sticky flags, set beats clear
    // A clear in the cycle of a new event leaves the flag set, so none is lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            brk_flag_r  <= 1'b0;
            sync_flag_r <= 1'b0;
        end else begin
            brk_flag_r  <= brk_hit | (brk_flag_r & ~brk_clr);
            sync_flag_r <= sync_end | (sync_flag_r & ~sync_clr);
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Line history, idle high like the line itself
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxd_d_r <= 1'b1;
        end else begin
            rxd_d_r <= lin_rxd;
        end
    end

    // Low time and span counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Sync edge counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            edge_r <= 4'h0;
        end else begin
            edge_r <= edge_nxt;
        end
    end

    // Captured sync span
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meas_r <= '0;
        end else begin
            meas_r <= meas_nxt;
        end
    end

    // Sync byte tail, open from the last measured edge to the stop bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tail_r <= 1'b0;
        end else begin
            tail_r <= tail_nxt;
        end
    end

    // UART receive line copy
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            uart_rxd <= 1'b1;
        end else begin
            uart_rxd <= uart_rxd_nxt;
        end
    end

    // Rate load pulse, rate and timer rewrite
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            uart_rate_load          <= 1'b0;
            uart_rate               <= '0;
            measure_timer_prescaler <= 8'h00;
            measure_timer_period    <= 16'h0000;
        end else begin
            uart_rate_load <= in_calc;
            if (in_calc) begin
                uart_rate               <= bit_time;
                measure_timer_prescaler <= prescaler_nxt;
                measure_timer_period    <= period_nxt;
            end
        end
    end

    // Shared header interrupt, one cycle behind the flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            header_interrupt <= 1'b0;
        end else begin
            header_interrupt <= irq_nxt;
        end
    end

endmodule : lin_slave_header_receiver

// [lin_hdr_asserts.sv]
`timescale 1ns/100ps
module lin_hdr_asserts #(
    parameter int MW = 20
) (
    // Clock and reset
    input wire logic          clk,
    input wire logic          rstn,
    // Bus handshake
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic          pready,
    input wire logic          pslverr,
    // Link and UART side
    input wire logic          lin_rxd,
    input wire logic          uart_rxd,
    input wire logic          uart_rate_load,
    input wire logic [MW-1:0] uart_rate,
    // Timer update and interrupt
    input wire logic [7:0]    measure_timer_prescaler,
    input wire logic [15:0]   measure_timer_period,
    input wire logic          header_interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Bus steps: open access phase, then the answer
    sequence access_s; psel && penable && !pready; endsequence
    sequence answer_s; pready ##1 !pready; endsequence
    chk_bus_answer: assert property (access_s |=> answer_s) else $error("bus answer late");
    chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    chk_rxd_copy: assert property (!uart_rxd |-> !$past(lin_rxd)) else $error("uart low w/o line");
    chk_rate_load: assert property ($changed(uart_rate) |-> uart_rate_load) else $error("rate moved");
    chk_load_pulse: assert property (uart_rate_load |=> !uart_rate_load) else $error("load too long");
    chk_timer_update: assert property (uart_rate_load |-> ##[0:1]
        (measure_timer_period == uart_rate[15:0] && measure_timer_prescaler == uart_rate[15:8]))
        else $error("timer not updated");
    // Interrupt only drops after a software write, never by itself
    chk_irq_hold: assert property ($fell(header_interrupt) |->
        $past(pready && pwrite) || $past(pready && pwrite, 2)) else $error("irq dropped");
    chk_no_stray: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
endmodule : lin_hdr_asserts
bind lin_slave_header_receiver lin_hdr_asserts #(.MW(MW)) u_chk (.*);

// [lin_master_model.sv]
`timescale 1ns/100ps
module lin_master_model #(
    parameter int BT = 8
) (
    // Bus line and frame markers
    input  wire logic clk,
    output logic      rxd,
    output logic      id_done,
    output logic      in_sync
);
    initial begin
        rxd = 1'b1;
        id_done = 1'b0;
        in_sync = 1'b0;
    end
    // One bit cell, changed just after an edge
    task automatic bit_out(input logic b);
        rxd <= b;
        repeat (BT) @(posedge clk);
    endtask : bit_out
    // Start bit, data LSB first, stop bit
    task automatic byte_out(input logic [7:0] d);
        bit_out(1'b0);
        for (int i = 0; i < 8; i++) bit_out(d[i]);
        bit_out(1'b1);
    endtask : byte_out
    // Break, delimiter, sync byte, identifier
    task automatic header(input logic [7:0] id);
        repeat (13) bit_out(1'b0);
        bit_out(1'b1);
        in_sync <= 1'b1;
        byte_out(8'h55);
        in_sync <= 1'b0;
        byte_out(id);
        id_done <= 1'b1;
        @(posedge clk);
        id_done <= 1'b0;
    endtask : header
endmodule : lin_master_model

// [tb_lin_slave_header_receiver.sv]
`timescale 1ns/100ps
module tb_lin_slave_header_receiver;
    import lin_hdr_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, measure_timer_prescaler;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, lin_rxd, uart_rxd, uart_rate_load, err;
    logic        uart_byte_valid, header_interrupt, in_sync;
    logic [19:0] uart_rate;
    logic [15:0] measure_timer_period;
    int          miscompares = 0, checked = 0, lows = 0, age = 0, base, loads = 0;
    lin_slave_header_receiver #(.MW(20)) uut (.*);
    lin_master_model m (.clk(clk), .rxd(lin_rxd), .id_done(uart_byte_valid), .in_sync(in_sync));
    always #20 clk = ~clk;
    // Low cycles passed to the UART in the sync byte after its first two cycles, and rate loads
    always @(posedge clk) begin
        age <= in_sync ? age + 1 : 0;
        if (in_sync && age > 1 && !uart_rxd) lows <= lows + 1;
        if (uart_rate_load === 1'b1) loads <= loads + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Setup cycle, then access held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    // Hang guard, far beyond two frames
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        apb(0, STATUS_OFFSET, 0);
        chk(rd, 0);
        apb(0, BRKLEN_OFFSET, 0);
        chk(rd, {16'h0, BRKLEN_RESET});
        apb(0, 8'h40, 0);
        chk({rd[30:0], err}, 1);
        apb(1, BRKLEN_OFFSET, 32'h10);
        $display("register test done");
        // Frame 0: withheld, break interrupt only; frame 1: passed, sync interrupt only
        for (int f = 0; f < 2; f++) begin
            apb(1, CTRL_OFFSET, f ? 32'h0000_000D : 32'h0000_0003);
            base = lows;
            m.header(8'h3C);
            repeat (4) @(posedge clk);
            chk(header_interrupt, 1);
            chk(uart_rate, 32'h0000_0008);
            chk({measure_timer_prescaler, measure_timer_period}, 32'h0000_0008);
            chk(lows != base, f);
            chk(loads, f + 1);
            apb(0, MEAS_OFFSET, 0);
            chk(rd, 32'h0000_0040);
            apb(0, TPER_OFFSET, 0);
            chk(rd, 32'h0000_0008);
            apb(0, STATUS_OFFSET, 0);
            chk(rd[1:0], 2'b11);
            chk(rd[RESP_BIT], 1);
            apb(1, STATUS_OFFSET, 3);
            apb(0, STATUS_OFFSET, 0);
            chk(rd[1:0], 0);
            repeat (3) @(posedge clk);
            chk(header_interrupt, 0);
            $display("frame %0d done", f);
        end
        test_done;
    end
endmodule : tb_lin_slave_header_receiver
